// ===== rtl/pio_bits_pkg.sv
// Constants for the parallel port bit-path block: register map, field positions, reset values
package pio_bits_pkg;
  // ******************************************************
  // Bus widths
  // ******************************************************
  localparam int ADDR_W = 5;
  localparam int DATA_W = 8;
  localparam int GP_W = 8;
  localparam int SP_W = 4;

  // ******************************************************
  // Per-port offsets for the two general ports (addr[3] picks the port)
  // ******************************************************
  localparam logic [2:0] OFS_DATA = 3'h0;
  localparam logic [2:0] OFS_DIR = 3'h1;
  localparam logic [2:0] OFS_POL = 3'h2;
  localparam logic [2:0] OFS_SIO = 3'h3;
  localparam logic [2:0] OFS_CSR = 3'h4;
  localparam logic [2:0] OFS_MODE = 3'h5;
  localparam logic [2:0] OFS_PVAL = 3'h6;
  localparam logic [2:0] OFS_PMASK = 3'h7;

  // ******************************************************
  // Special port and shared configuration addresses
  // ******************************************************
  localparam logic [4:0] ADDR_SP_DATA = 5'h10;
  localparam logic [4:0] ADDR_SP_DIR = 5'h11;
  localparam logic [4:0] ADDR_SP_POL = 5'h12;
  localparam logic [4:0] ADDR_SP_SIO = 5'h13;
  localparam logic [4:0] ADDR_CFG = 5'h14;

  // ******************************************************
  // Field positions
  // ******************************************************
  localparam int CSR_IP = 5;
  localparam int CSR_IE = 6;
  localparam int CSR_IUS = 7;
  localparam int MODE_HS = 0;
  localparam int CFG_LINK = 0;
  localparam int CFG_CT_B = 1;
  localparam int CFG_CT_C = 2;
  localparam int SP_MASK_LSB = 4;

  // ******************************************************
  // Reset values
  // ******************************************************
  localparam logic [7:0] GP_DIR_RST = 8'hff;
  localparam logic [3:0] SP_DIR_RST = 4'hf;
  localparam logic [7:0] REG_RST = 8'h00;
  localparam logic [3:0] SP_RST = 4'h0;
endpackage

// ===== rtl/pio_bit_paths.sv
// Bit-level I/O paths of two 8-bit general ports and one 4-bit special port
// Function
// - Direction bit one input, zero output
// - Polarity bit one inverts the data path
// - Input read returns level just before read
// - Special control one on input adds catcher
// - Catcher holds one until software clears it
// - Writing zero clears an enabled catcher
// - Other writes to input bits are ignored
// - General port reads return driven output value
// - Special port reads return real pin levels
// - Special control one makes output open-drain
// - Special port upper data bits mask paired lower bits
// - Masked bits keep state, unmasked take value
// - General ports give sixteen direction-programmable bits
// - General ports can link as 16-bit port
// - General ports detect patterns and request interrupt
// - Special port has no pattern detection
// - Special lines carry handshake and request/wait
// - Free special bits are I/O or timer lines
// - Second port lines give timer access
// - Command/status holds pending, in-service, enable bits
// - Handshake mode overrides the direction register
`timescale 1ns/1ns
`default_nettype none
module pio_bit_paths
  import pio_bits_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  output logic [DATA_W-1:0] reg_rdata,
  input wire logic [GP_W-1:0] first_port_lines_in,
  output logic [GP_W-1:0] first_port_lines_out,
  output logic [GP_W-1:0] first_port_lines_oe,
  input wire logic [GP_W-1:0] second_port_lines_in,
  output logic [GP_W-1:0] second_port_lines_out,
  output logic [GP_W-1:0] second_port_lines_oe,
  input wire logic [SP_W-1:0] special_port_lines_in,
  output logic [SP_W-1:0] special_port_lines_out,
  output logic [SP_W-1:0] special_port_lines_oe,
  input wire logic [1:0] hs_port_dir,
  input wire logic [SP_W-1:0] hs_special_use,
  input wire logic [SP_W-1:0] hs_special_drive,
  input wire logic [SP_W-1:0] hs_special_en,
  output logic [SP_W-1:0] hs_special_level,
  output logic [GP_W-1:0] timer_second_levels,
  output logic [SP_W-1:0] timer_special_levels,
  output logic [1:0] pattern_irq
);

  // ******************************************************
  // Storage
  // ******************************************************
  logic [GP_W-1:0] s1_q [2];
  logic [GP_W-1:0] s2_q [2];
  logic [GP_W-1:0] dir_q [2];
  logic [GP_W-1:0] pol_q [2];
  logic [GP_W-1:0] sio_q [2];
  logic [GP_W-1:0] out_q [2];
  logic [GP_W-1:0] catch_q [2];
  logic [GP_W-1:0] pval_q [2];
  logic [GP_W-1:0] pmask_q [2];
  logic [DATA_W-1:0] mode_q [2];
  logic [1:0] ip_q;
  logic [1:0] ie_q;
  logic [1:0] ius_q;
  logic [1:0] match_q;
  logic [SP_W-1:0] sp_s1_q;
  logic [SP_W-1:0] sp_s2_q;
  logic [SP_W-1:0] sp_dir_q;
  logic [SP_W-1:0] sp_pol_q;
  logic [SP_W-1:0] sp_sio_q;
  logic [SP_W-1:0] sp_out_q;
  logic [SP_W-1:0] sp_catch_q;
  logic [DATA_W-1:0] cfg_q;

  // ******************************************************
  // Combinational path values
  // ******************************************************
  logic [GP_W-1:0] path [2];
  logic [GP_W-1:0] dir_eff [2];
  logic [GP_W-1:0] catch_en [2];
  logic [GP_W-1:0] phys [2];
  logic [GP_W-1:0] oe_d [2];
  logic [GP_W-1:0] rd_val [2];
  logic [1:0] gp_wr;
  logic [1:0] match;
  logic [SP_W-1:0] sp_path;
  logic [SP_W-1:0] sp_dir_eff;
  logic [SP_W-1:0] sp_catch_en;
  logic [SP_W-1:0] sp_phys;
  logic [SP_W-1:0] sp_wmask;
  logic [SP_W-1:0] sp_rd;
  logic [DATA_W-1:0] rdata_d;
  logic link;

  // Pin inputs pass two flip-flops before any logic reads them
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      s1_q[0] <= REG_RST;
      s1_q[1] <= REG_RST;
      s2_q[0] <= REG_RST;
      s2_q[1] <= REG_RST;
      sp_s1_q <= SP_RST;
      sp_s2_q <= SP_RST;
    end
    else
    begin
      s1_q[0] <= first_port_lines_in;
      s1_q[1] <= second_port_lines_in;
      s2_q[0] <= s1_q[0];
      s2_q[1] <= s1_q[1];
      sp_s1_q <= special_port_lines_in;
      sp_s2_q <= sp_s1_q;
    end
  end

  assign link = cfg_q[CFG_LINK];

  // General port bit paths, one set per port
  always_comb
  begin
    for (int p = 0; p < 2; p++)
    begin
      path[p] = s2_q[p] ^ pol_q[p];
      dir_eff[p] = mode_q[p][MODE_HS] ? {GP_W{hs_port_dir[p]}} : dir_q[p];
      catch_en[p] = sio_q[p] & dir_eff[p] & ~{GP_W{mode_q[p][MODE_HS]}};
      phys[p] = out_q[p] ^ pol_q[p];
      oe_d[p] = ~dir_eff[p] & (~sio_q[p] | ~phys[p]);
      rd_val[p] = (dir_eff[p] & ((catch_en[p] & catch_q[p]) | (~catch_en[p] & path[p])))
                | (~dir_eff[p] & out_q[p]);
      gp_wr[p] = reg_we && !reg_addr[4] && (reg_addr[3] == p[0]);
    end
  end

  // Pattern compare; linked mode compares all sixteen lines on the first port
  always_comb
  begin
    if (link)
    begin
      match[0] = ((({path[1], path[0]} ^ {pval_q[1], pval_q[0]}) & {pmask_q[1], pmask_q[0]}) == 16'h0000)
               && (|{pmask_q[1], pmask_q[0]});
      match[1] = 1'b0;
    end
    else
    begin
      match[0] = (((path[0] ^ pval_q[0]) & pmask_q[0]) == 8'h00) && (|pmask_q[0]);
      match[1] = (((path[1] ^ pval_q[1]) & pmask_q[1]) == 8'h00) && (|pmask_q[1]);
    end
  end

  // Special port paths; handshake lines belong to the handshake logic
  always_comb
  begin
    sp_path = sp_s2_q ^ sp_pol_q;
    sp_dir_eff = sp_dir_q | hs_special_use;
    sp_catch_en = sp_sio_q & sp_dir_eff & ~hs_special_use;
    sp_phys = sp_out_q ^ sp_pol_q;
    sp_wmask = ~reg_wdata[SP_MASK_LSB +: SP_W];
    sp_rd = (sp_catch_en & sp_catch_q) | (~sp_catch_en & sp_path);
  end

  // Per-port configuration registers
  always_ff @(posedge mclk)
  begin
    for (int p = 0; p < 2; p++)
    begin
      if (!rst_n)
      begin
        dir_q[p] <= GP_DIR_RST;
        pol_q[p] <= REG_RST;
        sio_q[p] <= REG_RST;
        mode_q[p] <= REG_RST;
        pval_q[p] <= REG_RST;
        pmask_q[p] <= REG_RST;
      end
      else if (gp_wr[p])
      begin
        unique case (reg_addr[2:0])
          OFS_DIR: dir_q[p] <= reg_wdata;
          OFS_POL: pol_q[p] <= reg_wdata;
          OFS_SIO: sio_q[p] <= reg_wdata;
          OFS_MODE: mode_q[p] <= reg_wdata;
          OFS_PVAL: pval_q[p] <= reg_wdata;
          OFS_PMASK: pmask_q[p] <= reg_wdata;
          default: ;
        endcase
      end
    end
  end

  // Output data: writes reach output bits only
  always_ff @(posedge mclk)
  begin
    for (int p = 0; p < 2; p++)
    begin
      if (!rst_n)
        out_q[p] <= REG_RST;
      else if (gp_wr[p] && reg_addr[2:0] == OFS_DATA)
        out_q[p] <= (out_q[p] & dir_eff[p]) | (reg_wdata & ~dir_eff[p]);
    end
  end

  // Ones-catchers: capture wins over a clearing write in the same cycle
  always_ff @(posedge mclk)
  begin
    for (int p = 0; p < 2; p++)
    begin
      if (!rst_n)
        catch_q[p] <= REG_RST;
      else if (gp_wr[p] && reg_addr[2:0] == OFS_DATA)
        catch_q[p] <= ((catch_q[p] & ~(catch_en[p] & ~reg_wdata)) | path[p]) & catch_en[p];
      else
        catch_q[p] <= (catch_q[p] | path[p]) & catch_en[p];
    end
  end

  // Command/status: pending set on a new match, set beats a software clear
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      ip_q <= 2'h0;
      ie_q <= 2'h0;
      ius_q <= 2'h0;
      match_q <= 2'h0;
    end
    else
    begin
      match_q <= match;
      for (int p = 0; p < 2; p++)
      begin
        if (gp_wr[p] && reg_addr[2:0] == OFS_CSR)
        begin
          ie_q[p] <= reg_wdata[CSR_IE];
          ius_q[p] <= reg_wdata[CSR_IUS];
          ip_q[p] <= reg_wdata[CSR_IP] | (match[p] & ~match_q[p]);
        end
        else if (match[p] && !match_q[p])
          ip_q[p] <= 1'b1;
      end
    end
  end

  // Special port registers, masked bit writes on the data register
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      sp_dir_q <= SP_DIR_RST;
      sp_pol_q <= SP_RST;
      sp_sio_q <= SP_RST;
      sp_out_q <= SP_RST;
      cfg_q <= REG_RST;
    end
    else if (reg_we)
    begin
      unique case (reg_addr)
        ADDR_SP_DATA: sp_out_q <= (sp_out_q & ~(sp_wmask & ~sp_dir_eff))
                                | (reg_wdata[SP_W-1:0] & sp_wmask & ~sp_dir_eff);
        ADDR_SP_DIR: sp_dir_q <= reg_wdata[SP_W-1:0];
        ADDR_SP_POL: sp_pol_q <= reg_wdata[SP_W-1:0];
        ADDR_SP_SIO: sp_sio_q <= reg_wdata[SP_W-1:0];
        ADDR_CFG: cfg_q <= reg_wdata;
        default: ;
      endcase
    end
  end

  // Special port catchers, clear also honours the write mask
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      sp_catch_q <= SP_RST;
    else if (reg_we && reg_addr == ADDR_SP_DATA)
      sp_catch_q <= ((sp_catch_q & ~(sp_catch_en & sp_wmask & ~reg_wdata[SP_W-1:0])) | sp_path)
                  & sp_catch_en;
    else
      sp_catch_q <= (sp_catch_q | sp_path) & sp_catch_en;
  end

  // Read mux
  always_comb
  begin
    rdata_d = REG_RST;
    if (!reg_addr[4])
    begin
      unique case (reg_addr[2:0])
        OFS_DATA: rdata_d = rd_val[reg_addr[3]];
        OFS_DIR: rdata_d = dir_q[reg_addr[3]];
        OFS_POL: rdata_d = pol_q[reg_addr[3]];
        OFS_SIO: rdata_d = sio_q[reg_addr[3]];
        OFS_CSR: rdata_d = {ius_q[reg_addr[3]], ie_q[reg_addr[3]], ip_q[reg_addr[3]], 5'h00};
        OFS_MODE: rdata_d = mode_q[reg_addr[3]];
        OFS_PVAL: rdata_d = pval_q[reg_addr[3]];
        OFS_PMASK: rdata_d = pmask_q[reg_addr[3]];
      endcase
    end
    else
    begin
      unique case (reg_addr)
        ADDR_SP_DATA: rdata_d = {4'h0, sp_rd};
        ADDR_SP_DIR: rdata_d = {4'h0, sp_dir_q};
        ADDR_SP_POL: rdata_d = {4'h0, sp_pol_q};
        ADDR_SP_SIO: rdata_d = {4'h0, sp_sio_q};
        ADDR_CFG: rdata_d = cfg_q;
        default: rdata_d = REG_RST;
      endcase
    end
  end

  // Read data stand one cycle after the strobe
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      reg_rdata <= REG_RST;
    else if (reg_re)
      reg_rdata <= rdata_d;
    else
      reg_rdata <= REG_RST;
  end

  // Registered pin drivers
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      first_port_lines_out <= REG_RST;
      first_port_lines_oe <= REG_RST;
      second_port_lines_out <= REG_RST;
      second_port_lines_oe <= REG_RST;
      special_port_lines_out <= SP_RST;
      special_port_lines_oe <= SP_RST;
    end
    else
    begin
      first_port_lines_out <= phys[0];
      first_port_lines_oe <= oe_d[0];
      second_port_lines_out <= phys[1];
      second_port_lines_oe <= oe_d[1];
      special_port_lines_out <= (hs_special_use & hs_special_drive) | (~hs_special_use & sp_phys);
      special_port_lines_oe <= (hs_special_use & hs_special_en)
                             | (~hs_special_use & ~sp_dir_q & (~sp_sio_q | ~sp_phys));
    end
  end

  // Levels to the handshake, timers and interrupt logic
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      hs_special_level <= SP_RST;
      timer_second_levels <= REG_RST;
      timer_special_levels <= SP_RST;
      pattern_irq <= 2'h0;
    end
    else
    begin
      hs_special_level <= sp_path;
      timer_second_levels <= cfg_q[CFG_CT_B] ? path[1] : REG_RST;
      timer_special_levels <= cfg_q[CFG_CT_C] ? (sp_path & ~hs_special_use) : SP_RST;
      pattern_irq <= ip_q & ie_q & ~ius_q;
    end
  end

  // ******************************************************
  // Checks
  // ******************************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  chk_input_no_drive: assert property (
    1'b1 |=> ((first_port_lines_oe & $past(dir_eff[0])) == 8'h00))
    else $error("input bit driven on first port");

  chk_polarity_out: assert property (
    1'b1 |=> (second_port_lines_out == ($past(out_q[1]) ^ $past(pol_q[1]))))
    else $error("polarity not applied to second port output");

  chk_read_input: assert property (
    (reg_re && reg_addr == 5'h00) |=>
      ((reg_rdata & $past(dir_eff[0] & ~catch_en[0])) == $past(path[0] & dir_eff[0] & ~catch_en[0])))
    else $error("input read differs from prior level");

  chk_catch_hold: assert property (
    (catch_q[0][0] && catch_en[0][0] && !gp_wr[0]) |=> catch_q[0][0] || !$past(catch_en[0][0]))
    else $error("catcher lost its one");

  chk_catch_clear: assert property (
    (gp_wr[0] && reg_addr[2:0] == OFS_DATA && catch_en[0][0] && !reg_wdata[0] && !path[0][0]) |=> !catch_q[0][0])
    else $error("catcher not cleared by zero write");

  chk_input_write_ignored: assert property (
    (gp_wr[1] && reg_addr[2:0] == OFS_DATA) |=> ((out_q[1] ^ $past(out_q[1])) & $past(dir_eff[1])) == 8'h00)
    else $error("write changed an input bit");

  chk_open_drain: assert property (
    1'b1 |=> ((first_port_lines_oe & first_port_lines_out & $past(sio_q[0])) == 8'h00))
    else $error("open-drain output drove high");

  chk_special_mask: assert property (
    (reg_we && reg_addr == ADDR_SP_DATA) |=>
      ((sp_out_q ^ $past(sp_out_q)) & $past(reg_wdata[SP_MASK_LSB +: SP_W])) == 4'h0)
    else $error("masked special bit changed");

  chk_link_pattern: assert property (
    link |=> !(ip_q[1] && !$past(ip_q[1]) && !$past(gp_wr[1])))
    else $error("second port matched while linked");

  cov_catch_set: cover property (catch_en[0][0] && !catch_q[0][0] ##1 catch_q[0][0]);
  cov_masked_write: cover property (reg_we && reg_addr == ADDR_SP_DATA && reg_wdata[7:4] != 4'h0);
  cov_pattern_irq: cover property (pattern_irq[0] ##1 pattern_irq[0]);

endmodule
`default_nettype wire

// ===== verif/pin_far_side.sv
// Model of the external devices wired to the three port pin groups
`timescale 1ns/1ns
`default_nettype none
module pin_far_side
  import pio_bits_pkg::*;
(
  input wire logic [GP_W-1:0] first_out,
  input wire logic [GP_W-1:0] first_oe,
  input wire logic [GP_W-1:0] first_ext_val,
  input wire logic [GP_W-1:0] first_ext_drv,
  output logic [GP_W-1:0] first_line,
  input wire logic [GP_W-1:0] second_out,
  input wire logic [GP_W-1:0] second_oe,
  input wire logic [GP_W-1:0] second_ext_val,
  input wire logic [GP_W-1:0] second_ext_drv,
  output logic [GP_W-1:0] second_line,
  input wire logic [SP_W-1:0] special_out,
  input wire logic [SP_W-1:0] special_oe,
  input wire logic [SP_W-1:0] special_ext_val,
  input wire logic [SP_W-1:0] special_ext_drv,
  output logic [SP_W-1:0] special_line
);
  // ******************************************************
  // Wire resolution
  // ******************************************************
  // Each line has a pull-up; any party driving low wins (wired-AND), so a
  // released open-drain line shows the far device or the pull-up level
  always_comb
  begin
    first_line = (first_out | ~first_oe) & (first_ext_val | ~first_ext_drv);
    second_line = (second_out | ~second_oe) & (second_ext_val | ~second_ext_drv);
    special_line = (special_out | ~special_oe) & (special_ext_val | ~special_ext_drv);
  end
endmodule
`default_nettype wire

// ===== verif/parallel_port_bit_paths_test.sv
// Self-checking testbench for the parallel port bit-path block
`timescale 1ns/1ns
`default_nettype none
module parallel_port_bit_paths_test;
  import pio_bits_pkg::*;
  logic mclk, rst_n, reg_we, reg_re;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata, reg_rdata, rv;
  logic [GP_W-1:0] fp_in, fp_out, fp_oe, fp_val, fp_drv;
  logic [GP_W-1:0] sc_in, sc_out, sc_oe, sc_val, sc_drv, tmr_b;
  logic [SP_W-1:0] sp_in, sp_out, sp_oe, sp_val, sp_drv;
  logic [SP_W-1:0] hs_use, hs_drive, hs_en, hs_level, tmr_c;
  logic [1:0] hs_dir, irq;
  int n_errors, cmp_count;

  pio_bit_paths pio_bit_paths_i (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata), .first_port_lines_in(fp_in),
    .first_port_lines_out(fp_out), .first_port_lines_oe(fp_oe), .second_port_lines_in(sc_in),
    .second_port_lines_out(sc_out), .second_port_lines_oe(sc_oe), .special_port_lines_in(sp_in),
    .special_port_lines_out(sp_out), .special_port_lines_oe(sp_oe), .hs_port_dir(hs_dir),
    .hs_special_use(hs_use), .hs_special_drive(hs_drive), .hs_special_en(hs_en),
    .hs_special_level(hs_level), .timer_second_levels(tmr_b), .timer_special_levels(tmr_c),
    .pattern_irq(irq));

  pin_far_side pin_far_side_i (.first_out(fp_out), .first_oe(fp_oe), .first_ext_val(fp_val),
    .first_ext_drv(fp_drv), .first_line(fp_in), .second_out(sc_out), .second_oe(sc_oe),
    .second_ext_val(sc_val), .second_ext_drv(sc_drv), .second_line(sc_in), .special_out(sp_out),
    .special_oe(sp_oe), .special_ext_val(sp_val), .special_ext_drv(sp_drv), .special_line(sp_in));

  // ******************************************************
  // Clock, bus and compare helpers
  // ******************************************************
  // Free-running 100 MHz clock
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // One-cycle write strobe beside address and data
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_we <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_we <= 1'b0;
  endtask

  // One-cycle read strobe; data is taken in the following cycle only
  task automatic rd(input logic [4:0] a, output logic [7:0] d);
    @(posedge mclk);
    reg_re <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_re <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  // Lets synchronisers and registered pins settle
  task automatic settle();
    repeat (4) @(posedge mclk);
    #1;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    $display("errors=%0d compares=%0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ******************************************************
  // Scenarios
  // ******************************************************
  // Reset state, plus an unmapped address that must read zero
  task automatic t_reset();
    rd(5'h01, rv);
    chk(rv, GP_DIR_RST);
    rd(ADDR_SP_DIR, rv);
    chk(rv, {4'h0, SP_DIR_RST});
    chk(fp_oe | sc_oe, 8'h00);
    wr(5'h15, 8'hff);
    rd(5'h15, rv);
    chk(rv, 8'h00);
  endtask

  // Mixed directions on the first port, then an inverted path
  task automatic t_dir_pol();
    fp_drv <= 8'hf0;
    fp_val <= 8'h30;
    wr(5'h01, 8'hf0);
    wr(5'h00, 8'ha5);
    settle();
    chk(fp_oe, 8'h0f);
    chk({4'h0, fp_out[3:0]}, 8'h05);
    rd(5'h00, rv);
    chk(rv, 8'h35);
    wr(5'h02, 8'hff);
    settle();
    chk({4'h0, fp_out[3:0]}, 8'h0a);
    rd(5'h00, rv);
    chk(rv, 8'hc5);
    wr(5'h02, 8'h00);
    wr(5'h01, 8'hff);
  endtask

  // Second port levels offered to the timers
  task automatic t_timer();
    sc_drv <= 8'hff;
    sc_val <= 8'h5a;
    wr(ADDR_CFG, 8'h02);
    settle();
    chk(tmr_b, 8'h5a);
    wr(ADDR_CFG, 8'h00);
    settle();
    chk(tmr_b, 8'h00);
  endtask

  // Short pulse caught and held until a zero is written
  task automatic t_catcher();
    sc_val <= 8'h00;
    wr(5'h0b, 8'h01);
    @(posedge mclk);
    sc_val <= 8'h01;
    repeat (3) @(posedge mclk);
    sc_val <= 8'h00;
    settle();
    rd(5'h08, rv);
    chk(rv, 8'h01);
    settle();
    rd(5'h08, rv);
    chk(rv, 8'h01);
    wr(5'h08, 8'h00);
    rd(5'h08, rv);
    chk(rv, 8'h00);
    wr(5'h0b, 8'h00);
  endtask

  // Masked special-port writes, open-drain drive and real pin readback
  task automatic t_special();
    wr(ADDR_SP_DIR, 8'h00);
    wr(ADDR_SP_DATA, 8'h0a);
    wr(ADDR_SP_DATA, 8'h35);
    settle();
    chk({4'h0, sp_out}, 8'h06);
    chk({4'h0, sp_oe}, 8'h0f);
    rd(ADDR_SP_DATA, rv);
    chk(rv, 8'h06);
    wr(ADDR_SP_SIO, 8'h0f);
    sp_drv <= 4'h2;
    sp_val <= 4'h0;
    settle();
    chk({4'h0, sp_oe}, 8'h09);
    rd(ADDR_SP_DATA, rv);
    chk(rv, 8'h04);
    sp_drv <= 4'h0;
  endtask

  // Pattern match raises the request; a status write clears it
  task automatic t_pattern();
    int i;
    fp_drv <= 8'hff;
    fp_val <= 8'h00;
    wr(5'h06, 8'h96);
    wr(5'h07, 8'hff);
    wr(5'h04, 8'h40);
    fp_val <= 8'h96;
    i = 0;
    while (irq[0] !== 1'b1 && i < 20)
    begin
      @(posedge mclk);
      i++;
    end
    #1;
    if (i == 20)
    begin
      n_errors++;
      summarize();
    end
    chk({7'h0, irq[1]}, 8'h00);
    rd(5'h04, rv);
    chk(rv & 8'he0, 8'h60);
    wr(5'h04, 8'h40);
    settle();
    chk({6'h0, irq}, 8'h00);
  endtask

  // Linked ports compare sixteen lines on the first port only
  task automatic t_link();
    wr(5'h0e, 8'h5a);
    wr(5'h0f, 8'hff);
    wr(5'h0c, 8'h40);
    wr(ADDR_CFG, 8'h01);
    sc_val <= 8'h5a;
    settle();
    chk({6'h0, irq}, 8'h01);
    wr(5'h04, 8'h40);
    wr(ADDR_CFG, 8'h00);
    settle();
    chk({6'h0, irq}, 8'h02);
  endtask

  // Handshake mode overrides direction; owned special bits follow handshake logic
  task automatic t_handshake();
    wr(5'h0d, 8'h01);
    hs_dir <= 2'b01;
    hs_use <= 4'h1;
    hs_drive <= 4'h1;
    hs_en <= 4'h1;
    wr(5'h08, 8'h3c);
    wr(ADDR_CFG, 8'h04);
    settle();
    chk(sc_oe, 8'hff);
    chk(sc_out, 8'h3c);
    chk({6'h0, sp_out[0], sp_oe[0]}, 8'h03);
    chk({4'h0, hs_level}, 8'h07);
    chk({4'h0, tmr_c}, 8'h06);
  endtask

  // ******************************************************
  // Main sequence
  // ******************************************************
  initial
  begin
    n_errors = 0;
    cmp_count = 0;
    rst_n = 1'b0;
    reg_we = 1'b0;
    reg_re = 1'b0;
    reg_addr = 5'h00;
    reg_wdata = 8'h00;
    fp_val = 8'h00;
    fp_drv = 8'h00;
    sc_val = 8'h00;
    sc_drv = 8'h00;
    sp_val = 4'h0;
    sp_drv = 4'h0;
    hs_dir = 2'b11;
    hs_use = 4'h0;
    hs_drive = 4'h0;
    hs_en = 4'h0;
    repeat (12) @(posedge mclk);
    rst_n <= 1'b1;
    t_reset();
    t_dir_pol();
    t_timer();
    t_catcher();
    t_special();
    t_pattern();
    t_link();
    t_handshake();
    summarize();
  end
endmodule
`default_nettype wire
